// ### psir_regs.sv
// Strap override, strap status, expanded control and interrupt control/status registers.
// Assumes a single AHB-Lite master, word transfers and event pulses on mclk_in.
`timescale 1ns/1ps
module psir_regs #(
   parameter int unsigned ADDR_W = 8
) (
   // Clock and reset.
   input wire logic mclk_in,
   input wire logic rst_n_in,
   // AHB-Lite slave port.
   input wire logic hsel_in,
   input wire logic [ADDR_W-1:0] haddr_in,
   input wire logic [1:0] htrans_in,
   input wire logic hwrite_in,
   input wire logic [2:0] hsize_in,
   input wire logic [31:0] hwdata_in,
   input wire logic hready_in,
   output logic [31:0] hrdata_out,
   output logic hreadyout_out,
   output logic hresp_out,
   // Strapping pins.
   input wire logic [1:0] phy_address_strap_in,
   input wire logic rmii_strap_in,
   // Event pulses: 7 jabber, 6 rx error, 5 page, 4 pd fault, 3 lp ack, 2 down, 1 rf, 0 up.
   input wire logic [7:0] phy_event_in,
   // Operating mode controls.
   output logic rmii_mode_out,
   output logic rmii_back_to_back_out,
   output logic nand_tree_mode_out,
   output logic energy_detect_powerdown_en_out,
   output logic [4:0] phy_address_out,
   // Interrupt.
   output logic irq_out
);

   if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr_w
      $error("psir_regs: ADDR_W must lie between 8 and 32");
   end

   psir_pkg::psir_ahb_req_s req;
   psir_pkg::psir_ahb_req_s next_req;
   psir_pkg::psir_strap_s strap_sync;
   psir_pkg::psir_strap_s strap;
   logic [1:0] settle_cnt;
   logic strap_done;
   logic [15:0] ovr;
   logic [15:0] next_ovr;
   logic [15:0] ctrl;
   logic [15:0] next_ctrl;
   logic [7:0] irq_en;
   logic [7:0] next_irq_en;
   logic [7:0] flags;
   logic [7:0] w1c;
   logic addr_take;
   logic rd_take;
   logic wr_ovr;
   logic wr_ctrl;
   logic wr_ics;
   logic rd_ics;

   function automatic logic [5:0] word_index(input logic [ADDR_W-1:0] addr);
      return addr[7:2];
   endfunction

   function automatic logic [15:0] sts_word(input psir_pkg::psir_strap_s s);
      logic [15:0] w;
      w = 16'h0000;
      w[psir_pkg::STS_ADDR_STRAP_LSB +: 2] = s.addr_strap;
      w[psir_pkg::STS_RMII_BIT] = s.rmii;
      return w;
   endfunction

   // Bus request decode.
   assign addr_take = hsel_in && htrans_in[psir_pkg::HTRANS_ACTIVE_BIT] && hready_in;
   assign rd_take = addr_take && !hwrite_in;
   assign rd_ics = rd_take && (word_index(haddr_in) == psir_pkg::IDX_ICS);
   assign wr_ovr = req.valid && req.write && (req.idx == psir_pkg::IDX_OVR);
   assign wr_ctrl = req.valid && req.write && (req.idx == psir_pkg::IDX_CTRL);
   assign wr_ics = req.valid && req.write && (req.idx == psir_pkg::IDX_ICS);

   // Every transfer completes with no wait state and an OKAY response.
   assign hreadyout_out = 1'b1;
   assign hresp_out = 1'b0;

   always_comb begin
      next_req = req;
      if (hready_in) begin
         next_req.valid = hsel_in && htrans_in[psir_pkg::HTRANS_ACTIVE_BIT];
         next_req.write = hwrite_in;
         next_req.idx = word_index(haddr_in);
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         req <= '0;
      end else begin
         req <= next_req;
      end
   end

   // Strap pins are synchronised, then caught once after reset release.
   psir_sync #(
      .W(3)
   ) u_strap_sync (
      .mclk_in(mclk_in),
      .rst_n_in(rst_n_in),
      .async_in({phy_address_strap_in, rmii_strap_in}),
      .sync_out(strap_sync)
   );

   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         settle_cnt <= 2'h0;
         strap_done <= 1'b0;
      end else if (!strap_done) begin
         if (settle_cnt == psir_pkg::STRAP_SETTLE) begin
            strap_done <= 1'b1;
         end else begin
            settle_cnt <= settle_cnt + 2'h1;
         end
      end
   end

   // Any non-zero address strap selects 3h, so only 0h and 3h are ever reported.
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         strap <= '0;
      end else if (!strap_done && settle_cnt == psir_pkg::STRAP_SETTLE) begin
         strap.addr_strap <= (strap_sync.addr_strap == 2'h0) ? psir_pkg::ADDR_STRAP_LOW
                                                             : psir_pkg::ADDR_STRAP_HIGH;
         strap.rmii <= strap_sync.rmii;
      end
   end

   assign phy_address_out = {3'h0, strap.addr_strap};

   // Strap override register; bit 10 stays zero.
   always_comb begin
      next_ovr = ovr;
      if (wr_ovr) begin
         next_ovr = hwdata_in[15:0] & psir_pkg::OVR_WMASK;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         ovr <= psir_pkg::OVR_RST;
      end else begin
         ovr <= next_ovr;
      end
   end

   // Back-to-back follows override bit 6 alone, whatever the RMII bit holds.
   assign rmii_back_to_back_out = ovr[psir_pkg::OVR_B2B_BIT];
   assign nand_tree_mode_out = ovr[psir_pkg::OVR_NAND_BIT];
   assign rmii_mode_out = ovr[psir_pkg::OVR_RMII_BIT];

   // Expanded control register.
   always_comb begin
      next_ctrl = ctrl;
      if (wr_ctrl) begin
         next_ctrl = hwdata_in[15:0];
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         ctrl <= psir_pkg::CTRL_RST;
      end else begin
         ctrl <= next_ctrl;
      end
   end

   assign energy_detect_powerdown_en_out = !ctrl[psir_pkg::CTRL_ENERGY_DETECT_OFF_BIT];

   // Interrupt enables, high byte of the control/status register.
   always_comb begin
      next_irq_en = irq_en;
      if (wr_ics) begin
         next_irq_en = hwdata_in[psir_pkg::ICS_EN_LSB +: 8];
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         irq_en <= psir_pkg::ICS_EN_RST;
      end else begin
         irq_en <= next_irq_en;
      end
   end

   // Event flags clear on a read or by writing ones to the low byte.
   assign w1c = wr_ics ? hwdata_in[7:0] : 8'h00;

   psir_evt_flags #(
      .N(psir_pkg::EVT_N)
   ) u_flags (
      .mclk_in(mclk_in),
      .rst_n_in(rst_n_in),
      .set_in(phy_event_in),
      .rd_clr_in(rd_ics),
      .w1c_in(w1c),
      .flags_out(flags)
   );

   assign irq_out = |(flags & irq_en);

   // Read data are registered in the address phase; writes in flight to the override, control and enable fields are forwarded, flag clears are not.
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         hrdata_out <= 32'h0000_0000;
      end else if (rd_take) begin
         case (word_index(haddr_in))
            psir_pkg::IDX_OVR: hrdata_out <= {16'h0000, next_ovr};
            psir_pkg::IDX_STS: hrdata_out <= {16'h0000, sts_word(strap)};
            psir_pkg::IDX_CTRL: hrdata_out <= {16'h0000, next_ctrl};
            psir_pkg::IDX_ICS: hrdata_out <= {16'h0000, next_irq_en, flags};
            default: hrdata_out <= 32'h0000_0000;
         endcase
      end
   end

   // Checks.
   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (!rst_n_in);

   a_b2b_write: assert property (wr_ovr |=> rmii_back_to_back_out == $past(hwdata_in[6]))
      else $error("back-to-back mode does not follow the override write");

   a_nand_write: assert property (wr_ovr |=> nand_tree_mode_out == $past(hwdata_in[5]))
      else $error("NAND tree mode does not follow the override write");

   a_rmii_reset_one: assert property ($past(!rst_n_in) |-> rmii_mode_out && !nand_tree_mode_out)
      else $error("RMII override or test override has the wrong reset value");

   a_addr_strap_legal: assert property (
      strap.addr_strap == 2'h0 || strap.addr_strap == 2'h3)
      else $error("address strap field holds an illegal value");

   a_sts_read_only: assert property (
      req.valid && req.write && req.idx == psir_pkg::IDX_STS |=> $stable(strap))
      else $error("strap status changed by a write");

   a_sts_rmii_read: assert property (
      rd_take && word_index(haddr_in) == psir_pkg::IDX_STS |=> hrdata_out[1] == strap.rmii)
      else $error("RMII strap status read back wrong");

   a_energy_detect_write: assert property (
      wr_ctrl |=> energy_detect_powerdown_en_out == !$past(hwdata_in[11]))
      else $error("energy-detect power-down does not follow bit 11");

   a_enable_write: assert property (wr_ics |=> irq_en == $past(hwdata_in[15:8]))
      else $error("interrupt enables do not follow the write");

   a_read_clears: assert property (rd_ics && phy_event_in == 8'h00 |=> flags == 8'h00)
      else $error("flags not cleared by a read");

   a_flags_w1c: assert property (
      wr_ics && phy_event_in == 8'h00 |=> (flags & $past(hwdata_in[7:0])) == 8'h00)
      else $error("flags not cleared by writing ones");

   a_mode_reset: assert property (
      $past(!rst_n_in) |-> !rmii_back_to_back_out && !energy_detect_powerdown_en_out)
      else $error("back-to-back or energy-detect control has the wrong reset value");

   a_enable_reset: assert property (
      $past(!rst_n_in) |-> irq_en == 8'h00 && !irq_out)
      else $error("interrupt enables not cleared by reset");

   a_rmii_write: assert property (wr_ovr |=> rmii_mode_out == $past(hwdata_in[1]))
      else $error("RMII mode does not follow the override write");

   a_ovr_read: assert property (
      rd_take && word_index(haddr_in) == psir_pkg::IDX_OVR && !wr_ovr
      |=> hrdata_out == {16'h0000, ovr})
      else $error("strap override read back wrong");

   a_ctrl_read: assert property (
      rd_take && word_index(haddr_in) == psir_pkg::IDX_CTRL && !wr_ctrl
      |=> hrdata_out == {16'h0000, ctrl})
      else $error("expanded control read back wrong");

   a_ics_read: assert property (
      rd_ics && !wr_ics
      |=> hrdata_out[15:8] == irq_en)
      else $error("interrupt enables read back wrong");

   a_addr_strap_zero: assert property (
      !strap_done && settle_cnt == psir_pkg::STRAP_SETTLE && strap_sync.addr_strap == 2'h0
      |=> strap.addr_strap == 2'h0)
      else $error("address strap 00 not reported as 00");

   a_addr_strap_three: assert property (
      !strap_done && settle_cnt == psir_pkg::STRAP_SETTLE && strap_sync.addr_strap != 2'h0
      |=> strap.addr_strap == 2'h3)
      else $error("non-zero address strap not reported as 11");

   a_rmii_capture: assert property (
      !strap_done && settle_cnt == psir_pkg::STRAP_SETTLE
      |=> strap.rmii == $past(strap_sync.rmii))
      else $error("RMII strap not captured");

   a_strap_hold: assert property (strap_done |=> $stable(strap))
      else $error("strap status changed after capture");

   a_phy_addr_legal: assert property (
      phy_address_out == 5'h00 || phy_address_out == 5'h03)
      else $error("management address other than 0h or 3h");

   a_event_sets: assert property (phy_event_in[7] |=> flags[7])
      else $error("jabber event did not set its flag");

   a_irq_raise: assert property (phy_event_in[6] && irq_en[6] && !wr_ics |=> irq_out)
      else $error("enabled event did not raise the interrupt");

   a_irq_masked: assert property (!irq_out && phy_event_in == 8'h00 && !wr_ics |=> !irq_out)
      else $error("interrupt rose with no event and no enable write");

   // Every event, with its enable set, must reach the interrupt on its own.
   for (genvar g = 0; g < psir_pkg::EVT_N; g++) begin : g_irq_each
      a_irq_each: assert property (phy_event_in[g] && irq_en[g] && !wr_ics |=> irq_out)
         else $error("enabled event did not raise the interrupt");
   end

   c_b2b_mode: cover property (wr_ovr && hwdata_in[6] && hwdata_in[1]);
   c_read_clear: cover property (flags != 8'h00 ##1 rd_ics ##1 flags == 8'h00);
   c_irq_rise: cover property (!irq_out ##1 irq_out);
   c_set_wins: cover property (rd_ics && phy_event_in != 8'h00);

endmodule

// ### psir_pkg.sv
// Constants and carrier types for the strap override and interrupt enable register bank.
// Assumes a 32-bit AHB-Lite slave port with one register per aligned word.
package psir_pkg;

   // Bus and register widths.
   localparam int unsigned DATA_W = 32;
   localparam int unsigned REG_W = 16;
   localparam int unsigned IDX_W = 6;
   localparam int unsigned EVT_N = 8;

   // Register indices; the byte address is four times the index.
   localparam logic [5:0] IDX_OVR = 6'h16;
   localparam logic [5:0] IDX_STS = 6'h17;
   localparam logic [5:0] IDX_CTRL = 6'h18;
   localparam logic [5:0] IDX_ICS = 6'h1b;

   // Strap override register.
   localparam logic [15:0] OVR_RST = 16'h0002;
   localparam logic [15:0] OVR_WMASK = 16'hfbff;
   localparam int unsigned OVR_B2B_BIT = 6;
   localparam int unsigned OVR_NAND_BIT = 5;
   localparam int unsigned OVR_RMII_BIT = 1;

   // Strap status register.
   localparam int unsigned STS_ADDR_STRAP_LSB = 13;
   localparam int unsigned STS_RMII_BIT = 1;
   localparam logic [1:0] ADDR_STRAP_LOW = 2'h0;
   localparam logic [1:0] ADDR_STRAP_HIGH = 2'h3;

   // Expanded control register.
   localparam logic [15:0] CTRL_RST = 16'h0801;
   localparam int unsigned CTRL_ENERGY_DETECT_OFF_BIT = 11;

   // Interrupt control/status register: enables in the high byte, flags in the low byte.
   localparam int unsigned ICS_EN_LSB = 8;
   localparam logic [7:0] ICS_EN_RST = 8'h00;

   // Synchroniser depth; straps are caught on the edge after this many edges following reset release.
   localparam logic [1:0] STRAP_SETTLE = 2'h2;

   // AHB transfer type bit that marks NONSEQ or SEQ.
   localparam int unsigned HTRANS_ACTIVE_BIT = 1;

   typedef struct packed {
      logic valid;
      logic write;
      logic [5:0] idx;
   } psir_ahb_req_s;

   typedef struct packed {
      logic [1:0] addr_strap;
      logic rmii;
   } psir_strap_s;

endpackage

// ### psir_sync.sv
// Two-flop synchroniser for a group of level inputs.
// Assumes the inputs are quasi-static pins from outside the mclk_in domain.
`timescale 1ns/1ps
module psir_sync #(
   parameter int unsigned W = 3
) (
   // Clock and reset.
   input wire logic mclk_in,
   input wire logic rst_n_in,
   // Asynchronous levels and their synchronised copies.
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);

   logic [W-1:0] meta;

   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         meta <= '0;
         sync_out <= '0;
      end else begin
         meta <= async_in;
         sync_out <= meta;
      end
   end

endmodule

// ### psir_evt_flags.sv
// Sticky event flags, cleared all at once by a read or bit by bit by writing ones.
// Assumes set pulses come from logic on the same clock.
`timescale 1ns/1ps
module psir_evt_flags #(
   parameter int unsigned N = 8
) (
   // Clock and reset.
   input wire logic mclk_in,
   input wire logic rst_n_in,
   // Events, clear controls and flags.
   input wire logic [N-1:0] set_in,
   input wire logic rd_clr_in,
   input wire logic [N-1:0] w1c_in,
   output logic [N-1:0] flags_out
);

   logic [N-1:0] next_flags;

   if (N < 1 || N > 16) begin : g_bad_n
      $error("psir_evt_flags: N must lie between 1 and 16");
   end

   // A set in the same cycle as a clear keeps the flag.
   always_comb begin
      next_flags = flags_out & ~(w1c_in | {N{rd_clr_in}});
      next_flags = next_flags | set_in;
   end

   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         flags_out <= '0;
      end else begin
         flags_out <= next_flags;
      end
   end

endmodule

// ### psir_ahb_mst.sv
// AHB-Lite master standing in for the station management controller.
// Assumes one slave whose hreadyout is returned to it as hready_in.
`timescale 1ns/1ps
module psir_ahb_mst (
   // Clock.
   input wire logic mclk_in,
   // Bus request and status.
   output logic hsel_out,
   output logic [7:0] haddr_out,
   output logic [1:0] htrans_out,
   output logic hwrite_out,
   output logic [2:0] hsize_out,
   output logic [31:0] hwdata_out,
   output logic timeout_out,
   // Bus answer.
   input wire logic hready_in,
   input wire logic [31:0] hrdata_in
);
   initial begin
      hsel_out = 1'b0;
      haddr_out = 8'h00;
      htrans_out = 2'h0;
      hwrite_out = 1'b0;
      hsize_out = 3'h2;
      hwdata_out = 32'h0000_0000;
      timeout_out = 1'b0;
   end

   // Holds the current phase until hready is seen high at a rising edge.
   task automatic wait_rdy();
      int n;
      n = 0;
      do begin
         @(posedge mclk_in);
         n++;
      end while (hready_in !== 1'b1 && n < 64);
      if (hready_in !== 1'b1) begin
         timeout_out <= 1'b1;
      end
   endtask

   // One single word transfer; called just after a rising edge.
   task automatic xfer(input logic wr, input logic [5:0] idx, input logic [15:0] wd,
                       output logic [31:0] rd);
      hsel_out <= 1'b1;
      haddr_out <= {idx, 2'h0};
      htrans_out <= 2'h2;
      hwrite_out <= wr;
      wait_rdy();
      hsel_out <= 1'b0;
      htrans_out <= 2'h0;
      if (wr) begin
         hwdata_out <= {16'h0000, wd};
      end
      wait_rdy();
      rd = hrdata_in;
      // A released data bus shows the inverse of its last value, never a stale copy.
      hwdata_out <= ~hwdata_out;
   endtask
endmodule

// ### phy_strap_and_irq_enable_regs_tb.sv
// Self-checking bench for the strap override and interrupt enable register bank.
// Assumes the AHB master model drives the bus and the bench drives straps and events.
`timescale 1ns/1ps
module phy_strap_and_irq_enable_regs_tb;
   typedef struct packed {
      logic [5:0] idx;
      logic [15:0] wd;
      logic [15:0] rd;
      logic [3:0] o;
   } psir_tb_row_s;

   // Outputs column is {rmii, back-to-back, nand tree, energy-detect enable}.
   localparam psir_tb_row_s ROWS[8] = '{
      '{psir_pkg::IDX_OVR, 16'h0042, 16'h0042, 4'hc},
      '{psir_pkg::IDX_OVR, 16'h0020, 16'h0020, 4'h2},
      '{psir_pkg::IDX_OVR, 16'hffff, 16'hfbff, 4'he},
      '{psir_pkg::IDX_CTRL, 16'h0000, 16'h0000, 4'hf},
      '{psir_pkg::IDX_CTRL, 16'h0801, 16'h0801, 4'he},
      '{psir_pkg::IDX_ICS, 16'hff00, 16'hff00, 4'he},
      '{6'h00, 16'hffff, 16'h0000, 4'he},
      '{psir_pkg::IDX_OVR, 16'h0002, 16'h0002, 4'h8}};
   localparam logic [1:0] SPIN[3] = '{2'h0, 2'h1, 2'h3};
   localparam logic SRMII[3] = '{1'b1, 1'b0, 1'b1};
   localparam logic [15:0] SSTS[3] = '{16'h0002, 16'h6000, 16'h6002};
   localparam logic [4:0] SADDR[3] = '{5'h00, 5'h03, 5'h03};

   logic mclk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic hsel, hwrite, hready, hresp, timeout;
   logic [7:0] haddr;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] hwdata, hrdata, rd;
   logic [1:0] strap = 2'h0;
   logic rmii_strap = 1'b1;
   logic [7:0] phy_event = 8'h00;
   logic rmii, b2b, nand_tree, edet_en, irq;
   logic [4:0] phy_addr;
   int error_cnt = 0;
   int tests_run = 0;

   always #5 mclk_in = ~mclk_in;

   psir_ahb_mst mst_u (.mclk_in(mclk_in), .hsel_out(hsel), .haddr_out(haddr),
      .htrans_out(htrans), .hwrite_out(hwrite), .hsize_out(hsize), .hwdata_out(hwdata),
      .timeout_out(timeout), .hready_in(hready), .hrdata_in(hrdata));

   psir_regs #(.ADDR_W(8)) dut_u (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .hsel_in(hsel),
      .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize),
      .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready),
      .hresp_out(hresp), .phy_address_strap_in(strap), .rmii_strap_in(rmii_strap),
      .phy_event_in(phy_event), .rmii_mode_out(rmii), .rmii_back_to_back_out(b2b),
      .nand_tree_mode_out(nand_tree), .energy_detect_powerdown_en_out(edet_en),
      .phy_address_out(phy_addr), .irq_out(irq));

   task automatic test_done();
      if (error_cnt == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic do_reset();
      rst_n_in <= 1'b0;
      repeat (4) @(posedge mclk_in);
      rst_n_in <= 1'b1;
      repeat (6) @(posedge mclk_in);
   endtask

   // Event pulse of one cycle; returns one edge after the flag has been set.
   task automatic pulse(input logic [7:0] e);
      phy_event <= e;
      @(posedge mclk_in);
      phy_event <= 8'h00;
      @(posedge mclk_in);
   endtask

   always @(posedge mclk_in) begin
      if (timeout === 1'b1 || hresp !== 1'b0) begin
         error_cnt++;
         test_done();
      end
   end

   initial begin
      repeat (20000) @(posedge mclk_in);
      error_cnt++;
      test_done();
   end

   initial begin
      do_reset();
      // The rows set back-to-back only together with the RMII override bit; the design does not tie them.
      for (int i = 0; i < 8; i++) begin
         mst_u.xfer(1'b1, ROWS[i].idx, ROWS[i].wd, rd);
         mst_u.xfer(1'b0, ROWS[i].idx, 16'h0000, rd);
         chk(rd, {16'h0000, ROWS[i].rd});
         chk({28'h0, rmii, b2b, nand_tree, edet_en}, {28'h0, ROWS[i].o});
      end
      for (int s = 0; s < 3; s++) begin
         strap <= SPIN[s];
         rmii_strap <= SRMII[s];
         do_reset();
         mst_u.xfer(1'b1, psir_pkg::IDX_STS, 16'h9ffd, rd);
         mst_u.xfer(1'b0, psir_pkg::IDX_STS, 16'h0000, rd);
         chk(rd, {16'h0000, SSTS[s]});
         chk({27'h0, phy_addr}, {27'h0, SADDR[s]});
         mst_u.xfer(1'b0, psir_pkg::IDX_OVR, 16'h0000, rd);
         chk(rd, 32'h0000_0002);
         mst_u.xfer(1'b0, psir_pkg::IDX_CTRL, 16'h0000, rd);
         chk(rd, 32'h0000_0801);
         mst_u.xfer(1'b0, psir_pkg::IDX_ICS, 16'h0000, rd);
         chk(rd, 32'h0000_0000);
         chk({27'h0, rmii, b2b, nand_tree, edet_en, irq}, 32'h0000_0010);
      end
      for (int i = 0; i < 8; i++) begin
         mst_u.xfer(1'b1, psir_pkg::IDX_ICS, 16'h0100 << i, rd);
         pulse(8'h01 << i);
         chk({31'h0, irq}, 32'h1);
         mst_u.xfer(1'b0, psir_pkg::IDX_ICS, 16'h0000, rd);
         chk(rd, {16'h0000, 16'h0101 << i});
         chk({31'h0, irq}, 32'h0);
         pulse(8'h01 << ((i + 1) % 8));
         chk({31'h0, irq}, 32'h0);
         mst_u.xfer(1'b1, psir_pkg::IDX_ICS, (16'h0100 << i) | (16'h0001 << ((i + 1) % 8)), rd);
         mst_u.xfer(1'b0, psir_pkg::IDX_ICS, 16'h0000, rd);
         chk(rd, {16'h0000, 16'h0100 << i});
      end
      fork
         mst_u.xfer(1'b0, psir_pkg::IDX_ICS, 16'h0000, rd);
         pulse(8'h80);
      join
      chk(rd, 32'h0000_8000);
      chk({31'h0, irq}, 32'h1);
      test_done();
   end
endmodule
